// *** logic/rivm_pkg.sv ***
// constants for the reset and interrupt vector mapper
package rivm_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_SRC = 25;
    localparam int IDX_W = 5;
    localparam logic [ADDR_W-1:0] RESET_ADDR_DEFAULT = 12'h000;
    localparam logic [ADDR_W-1:0] VEC_BASE_DEFAULT = 12'h001;
    localparam logic [ADDR_W-1:0] VEC_STEP = 12'h001;
    localparam logic [ADDR_W-1:0] BOOT_START_DEFAULT = 12'hc00;
    localparam logic FUSE_UNPROGRAMMED = 1'b1;
    localparam int MCR_RELOCATE_BIT = 1;
    localparam logic [7:0] MCR_RESET = 8'h00;
    // source index = vector number minus two
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_PC0 = 2;
    localparam int SRC_PC1 = 3;
    localparam int SRC_PC2 = 4;
    localparam int SRC_WDOG = 5;
    localparam int SRC_T2A = 6;
    localparam int SRC_T2B = 7;
    localparam int SRC_T2W = 8;
    localparam int SRC_T1C = 9;
    localparam int SRC_T1A = 10;
    localparam int SRC_T1B = 11;
    localparam int SRC_T1W = 12;
    localparam int SRC_T0A = 13;
    localparam int SRC_T0B = 14;
    localparam int SRC_T0W = 15;
    localparam int SRC_SPI = 16;
    localparam int SRC_RXC = 17;
    localparam int SRC_TXE = 18;
    localparam int SRC_TXC = 19;
    localparam int SRC_ADC = 20;
    localparam int SRC_NV = 21;
    localparam int SRC_ACMP = 22;
    localparam int SRC_TWI = 23;
    localparam int SRC_PGM = 24;
endpackage

// *** logic/rivm_prio_enc.sv ***
// lowest-index-wins priority encoder
`timescale 1ns/1ps
module rivm_prio_enc #(
    parameter int WIDTH = 25,
    parameter int IDX_W = 5
) (
    input wire logic [WIDTH-1:0] req_in,
    output logic any_out,
    output logic [IDX_W-1:0] idx_out
);
    always_comb begin
        any_out = 1'b0;
        idx_out = '0;
        // scan downward so the lowest set bit is the last written
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                any_out = 1'b1;
                idx_out = IDX_W'(i);
            end
        end
    end
endmodule

// *** logic/rivm_vector_mapper.sv ***
// reset and interrupt vector address generator
`timescale 1ns/1ps
// Function
// - fuse unprogrammed: fetch starts at 0x0000 after any system reset
// - default: external request zero to 0x0001, one to 0x0002
// - default: pin change requests zero to two at 0x0003 to 0x0005
// - default: watchdog 0x0006, timer two a, b, wrap 0x0007 to 0x0009
// - default: timer one capture, a, b, wrap at 0x000a to 0x000d
// - default: timer zero a, b, wrap at 0x000e to 0x0010
// - default: spi 0x0011, serial rx, tx empty, tx done through 0x0014
// - default: converter, nv ready, comparator, two-wire, store ready 0x0015-0x0019
// - fuse programmed: reset fetch goes to boot loader start
// - relocate bit set: vector equals table address plus boot start
// - reset 0x000 or boot; vectors from 0x001 or boot plus 0x0001
// - fuse value one is unprogrammed, zero is programmed
// - one word per vector; consecutive numbers, consecutive addresses
// - relocate bit lives in the mcu control register
module rivm_vector_mapper (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic boot_reset_select_fuse_in,
    input wire logic [rivm_pkg::ADDR_W-1:0] boot_start_in,
    input wire logic mcr_write_in,
    input wire logic [7:0] mcr_wdata_in,
    input wire logic [rivm_pkg::NUM_SRC-1:0] irq_req_in,
    input wire logic irq_take_in,
    output logic [7:0] mcu_control_register_out,
    output logic pc_load_out,
    output logic [rivm_pkg::ADDR_W-1:0] pc_addr_out,
    output logic is_reset_vec_out
);
    logic [7:0] mcr_reg;
    logic rst_seen_reg;
    logic pc_load_reg;
    logic [rivm_pkg::ADDR_W-1:0] pc_addr_reg;
    logic is_reset_reg;
    logic fuse_reg;
    wire logic any_req;
    wire logic [rivm_pkg::IDX_W-1:0] win_idx;
    wire logic vector_relocate_bit;
    wire logic fuse_unprog;
    wire logic [rivm_pkg::ADDR_W-1:0] reset_addr;
    wire logic [rivm_pkg::ADDR_W-1:0] vec_base;
    wire logic [rivm_pkg::ADDR_W-1:0] vec_addr;

    rivm_prio_enc #(.WIDTH(rivm_pkg::NUM_SRC), .IDX_W(rivm_pkg::IDX_W)) u_prio (
        .req_in(irq_req_in),
        .any_out(any_req),
        .idx_out(win_idx)
    );

    assign vector_relocate_bit = mcr_reg[rivm_pkg::MCR_RELOCATE_BIT];
    // fuse is a static strap, caught once at reset release
    assign fuse_unprog = (fuse_reg == rivm_pkg::FUSE_UNPROGRAMMED);
    assign reset_addr = fuse_unprog ? rivm_pkg::RESET_ADDR_DEFAULT : boot_start_in;
    assign vec_base = vector_relocate_bit ? (boot_start_in + rivm_pkg::VEC_STEP)
                                          : rivm_pkg::VEC_BASE_DEFAULT;
    // one word per entry, so the source index is the word offset
    assign vec_addr = vec_base + rivm_pkg::ADDR_W'(win_idx);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mcr_reg <= rivm_pkg::MCR_RESET;
        end else if (mcr_write_in) begin
            mcr_reg <= mcr_wdata_in;
        end
    end

    // the fuse strap sits outside the clock domain, so two flops settle it first
    // no reset on this chain: it must keep filling while reset is held
    // limitation: the strap has to be steady two cycles before reset is released
    logic fuse_meta_reg;
    logic fuse_sync_reg;
    always_ff @(posedge clk_sys_in) begin
        fuse_meta_reg <= boot_reset_select_fuse_in;
        fuse_sync_reg <= fuse_meta_reg;
    end

    // one-shot marker for the first cycle out of reset
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rst_seen_reg <= 1'b1;
            fuse_reg <= rivm_pkg::FUSE_UNPROGRAMMED;
        end else begin
            rst_seen_reg <= 1'b0;
            if (rst_seen_reg) begin
                fuse_reg <= fuse_sync_reg;
            end
        end
    end

    // reset fetch issued one cycle after the fuse is captured
    wire logic reset_fetch;
    logic fetch_pend_reg;
    assign reset_fetch = fetch_pend_reg;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            fetch_pend_reg <= 1'b0;
        end else begin
            fetch_pend_reg <= rst_seen_reg;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pc_load_reg <= 1'b0;
            pc_addr_reg <= rivm_pkg::RESET_ADDR_DEFAULT;
            is_reset_reg <= 1'b0;
        end else if (reset_fetch) begin
            pc_load_reg <= 1'b1;
            pc_addr_reg <= reset_addr;
            is_reset_reg <= 1'b1;
        end else if (irq_take_in && any_req) begin
            pc_load_reg <= 1'b1;
            pc_addr_reg <= vec_addr;
            is_reset_reg <= 1'b0;
        end else begin
            pc_load_reg <= 1'b0;
            is_reset_reg <= 1'b0;
        end
    end

    assign mcu_control_register_out = mcr_reg;
    assign pc_load_out = pc_load_reg;
    assign pc_addr_out = pc_addr_reg;
    assign is_reset_vec_out = is_reset_reg;

    // reset path: release, pending fetch, then the reset load
    sequence seq_reset_release;
        $fell(rst_in);
    endsequence

    sequence seq_reset_load;
        ##1 reset_fetch ##1 (pc_load_out && is_reset_vec_out);
    endsequence

    chk_reset_once: assert property (@(posedge clk_sys_in)
        seq_reset_release |-> seq_reset_load)
        else $error("reset fetch not issued");

    // no disable here: this one must hold while reset is asserted
    chk_reset_clears: assert property (@(posedge clk_sys_in)
        rst_in |=> !pc_load_out && !is_reset_vec_out && mcu_control_register_out == rivm_pkg::MCR_RESET)
        else $error("reset left outputs active");

    chk_reset_fetch_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reset_fetch |=> pc_load_out && is_reset_vec_out &&
            pc_addr_out == (fuse_unprog ? 12'h000 : boot_start_in))
        else $error("reset fetch address wrong");

    chk_reset_flag_pair: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        is_reset_vec_out |-> pc_load_out)
        else $error("reset flag without a load");

    // vector path
    chk_vec_default: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!reset_fetch && irq_take_in && any_req && !vector_relocate_bit)
            |=> pc_load_out && pc_addr_out == 12'h001 + 12'($past(win_idx)))
        else $error("default vector address wrong");

    // relocation adds the boot start to every table slot
    chk_vec_relocate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!reset_fetch && irq_take_in && any_req && vector_relocate_bit)
            |=> pc_addr_out == $past(boot_start_in) + 12'h001 + 12'($past(win_idx)))
        else $error("relocated vector address wrong");

    chk_ext0_first: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!reset_fetch && irq_take_in && irq_req_in[0] && !vector_relocate_bit) |=> pc_addr_out == 12'h001)
        else $error("lowest source did not win");

    chk_last_vector: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!reset_fetch && irq_take_in && irq_req_in == 25'h1000000 && !vector_relocate_bit)
            |=> pc_addr_out == 12'h019)
        else $error("store ready vector wrong");

    chk_vec_in_table: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (pc_load_out && !is_reset_vec_out && !$past(vector_relocate_bit))
            |-> pc_addr_out >= 12'h001 && pc_addr_out <= 12'h019)
        else $error("default vector outside the table");

    // a load with no cause would send the core into a stray handler
    chk_no_spurious: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!reset_fetch && !(irq_take_in && any_req)) |=> !pc_load_out)
        else $error("spurious pc load");

    chk_load_cause: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (pc_load_out && !is_reset_vec_out) |-> $past(irq_take_in && any_req))
        else $error("vector load without a take");

    // the core may read pc_addr_out late, so it must not drift between loads
    chk_addr_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(reset_fetch || (irq_take_in && any_req)) |=> $stable(pc_addr_out))
        else $error("fetch address moved without a load");

    // priority encoder
    chk_prio_winner: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        any_req |-> irq_req_in[win_idx])
        else $error("winner index not requesting");

    chk_prio_lower: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        any_req |->
            (irq_req_in & ((rivm_pkg::NUM_SRC'(1) << win_idx) - rivm_pkg::NUM_SRC'(1))) == '0)
        else $error("lower source was passed over");

    chk_any_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        any_req == (|irq_req_in))
        else $error("request summary wrong");

    // control register and fuse strap
    chk_relocate_bit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        mcr_write_in |=> vector_relocate_bit == $past(mcr_wdata_in[rivm_pkg::MCR_RELOCATE_BIT]))
        else $error("relocate bit not stored");

    chk_mcr_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        mcr_write_in |=> mcu_control_register_out == $past(mcr_wdata_in))
        else $error("control register write lost");

    chk_mcr_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !mcr_write_in |=> $stable(mcu_control_register_out))
        else $error("control register changed without a write");

    // the fuse is taken from the settled copy, never from the raw pin
    chk_fuse_capture: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (rst_seen_reg && !rst_in) |=> fuse_reg == $past(fuse_sync_reg))
        else $error("fuse not captured at release");

    chk_fuse_steady: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !rst_seen_reg |=> $stable(fuse_reg))
        else $error("fuse copy changed after release");
endmodule

// *** bench/rivm_core_model.sv ***
// core-side model: asks for vectors and records each fetch address
`timescale 1ns/1ps
module rivm_core_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic fetch_want_in,
    input wire logic slow_in,
    input wire logic pc_load_in,
    input wire logic [rivm_pkg::ADDR_W-1:0] pc_addr_in,
    output logic irq_take_out,
    output logic fetch_seen_out,
    output logic [rivm_pkg::ADDR_W-1:0] fetch_addr_out
);
    logic pend_reg;
    // slow mode takes one cycle late, like a core finishing a longer instruction
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pend_reg <= 1'b0;
            irq_take_out <= 1'b0;
            fetch_seen_out <= 1'b0;
            fetch_addr_out <= '0;
        end else begin
            pend_reg <= fetch_want_in & slow_in;
            irq_take_out <= (fetch_want_in & ~slow_in) | pend_reg;
            fetch_seen_out <= pc_load_in;
            // only the address is kept; slot contents are the program's business
            if (pc_load_in) begin
                fetch_addr_out <= pc_addr_in;
            end
        end
    end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the vector mapper
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic fuse = 1'b1;
    logic [rivm_pkg::ADDR_W-1:0] boot_start = 12'h700;
    logic mcr_write = 1'b0;
    logic [7:0] mcr_wdata = 8'h00;
    logic [rivm_pkg::NUM_SRC-1:0] irq_req = '0;
    logic want = 1'b0;
    logic slow = 1'b0;
    logic irq_take, pc_load, is_reset, seen;
    logic [7:0] mcr;
    logic [rivm_pkg::ADDR_W-1:0] pc_addr, fetch_addr;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    rivm_vector_mapper u_rivm_vector_mapper (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .boot_reset_select_fuse_in(fuse), .boot_start_in(boot_start), .mcr_write_in(mcr_write),
        .mcr_wdata_in(mcr_wdata), .irq_req_in(irq_req), .irq_take_in(irq_take),
        .mcu_control_register_out(mcr), .pc_load_out(pc_load), .pc_addr_out(pc_addr),
        .is_reset_vec_out(is_reset));
    rivm_core_model u_rivm_core_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .fetch_want_in(want),
        .slow_in(slow), .pc_load_in(pc_load), .pc_addr_in(pc_addr), .irq_take_out(irq_take),
        .fetch_seen_out(seen), .fetch_addr_out(fetch_addr));
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a hung handshake would otherwise stall the run forever
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reset_case(input logic f, input logic [11:0] exp);
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        fuse <= f;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check_val({4'h0, pc_addr}, {4'h0, exp});
        check_val({14'h0000, pc_load, is_reset}, 16'h0003);
        check_val({8'h00, mcr}, 16'h0000);
    endtask
    task automatic irq_case(input logic [24:0] req, input logic s, input logic ld, input logic [11:0] exp);
        logic [3:0] loads;
        logic rst_flag;
        loads = 4'h0;
        rst_flag = 1'b0;
        @(posedge clk_sys_in);
        irq_req <= req;
        want <= 1'b1;
        slow <= s;
        @(posedge clk_sys_in);
        want <= 1'b0;
        repeat (5) begin
            @(posedge clk_sys_in);
            #1;
            loads = loads + 4'(seen === 1'b1);
            rst_flag = rst_flag | (pc_load === 1'b1 && is_reset !== 1'b0);
        end
        check_val({12'h000, loads}, {15'h0000, ld});
        check_val({15'h0000, rst_flag}, 16'h0000);
        if (ld) check_val({4'h0, fetch_addr}, {4'h0, exp});
        @(posedge clk_sys_in);
        irq_req <= '0;
    endtask
    task automatic write_mcr(input logic [7:0] v);
        @(posedge clk_sys_in);
        mcr_write <= 1'b1;
        mcr_wdata <= v;
        @(posedge clk_sys_in);
        mcr_write <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        check_val({8'h00, mcr}, {8'h00, v});
    endtask
    initial begin
        reset_case(1'b1, 12'h000);
        for (int i = 0; i < rivm_pkg::NUM_SRC; i++) begin
            irq_case(25'h1 << i, i[0], 1'b1, 12'h001 + 12'(i));
        end
        irq_case(25'h1100020, 1'b0, 1'b1, 12'h006);
        irq_case('0, 1'b0, 1'b0, 12'h000);
        write_mcr(8'h02);
        irq_case(25'h0000001, 1'b0, 1'b1, 12'h701);
        irq_case(25'h1000000, 1'b1, 1'b1, 12'h719);
        reset_case(1'b0, 12'h700);
        irq_case(25'h0000004, 1'b0, 1'b1, 12'h003);
        write_mcr(8'h02);
        irq_case(25'h0000010, 1'b1, 1'b1, 12'h705);
        final_report();
    end
endmodule
